//--- rtl/fsbe_pkg.sv
package fsbe_pkg;

   localparam int FL_AW = 24;

   // apb register byte offsets
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_ADDR   = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;

   // ctrl operation codes
   localparam logic [1:0] OP_NONE  = 2'h0;
   localparam logic [1:0] OP_ERASE = 2'h1;
   localparam logic [1:0] OP_CLEAR = 2'h2;
   localparam logic [1:0] OP_READ  = 2'h3;

   // status register field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_RB_BIT   = 2;
   localparam int ST_BYTE_LSB = 8;

   // operation_status bit positions
   localparam int OS_READY   = 7;
   localparam int OS_ESUSP   = 6;
   localparam int OS_ERASE   = 5;
   localparam int OS_PROG    = 4;
   localparam int OS_SUPPLY  = 3;
   localparam int OS_PSUSP   = 2;
   localparam int OS_LOCK    = 1;
   localparam int OS_RSVD    = 0;
   localparam logic [7:0] OS_MASK = 8'hfe;

   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

   // timing, ns and derived pclk cycles at 50 ns
   localparam int CLK_NS       = 50;
   localparam int T_WE_LOW_NS  = 70;
   localparam int T_READ_NS    = 150;
   localparam int SYNC_CYC     = 2;
   localparam int WE_CYC       = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_CYC       = (T_READ_NS + CLK_NS - 1) / CLK_NS
                                 + SYNC_CYC;
   localparam int CNT_W        = 16;
   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

   typedef enum logic [3:0] {
      S_IDLE, S_WSETUP, S_WPULSE, S_WHOLD, S_WGAP,
      S_WB, S_RPULSE, S_RGAP
   } fsbe_st_type;

   typedef struct packed {
      logic             ce_n;
      logic             oe_n;
      logic             we_n;
      logic [FL_AW-1:0] addr;
      logic [7:0]       dq_out;
      logic             dq_oe;
   } fsbe_pins_type;

   localparam fsbe_pins_type PINS_IDLE =
      '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0,
        dq_out: 8'h00, dq_oe: 1'b0};

   typedef struct packed {
      fsbe_st_type      st;
      logic [1:0]       op;
      logic             idx;
      logic [CNT_W-1:0] cnt;
      logic [FL_AW-1:0] addr;
      logic             done;
      logic [7:0]       stat;
      fsbe_pins_type    pins;
      logic [7:0]       dq_s1;
      logic [7:0]       dq_s2;
      logic             rb_s1;
      logic             rb_s2;
   } fsbe_state_type;

endpackage

//--- rtl/fsbe_ctrl.sv
// Functional notes
// - bit 0 reserved, host masks it
// - host clears errors by writing 50h
// - erase is setup write then confirm write
// - host polls bit 7 toggling output enable
`timescale 1ns/1ps
module fsbe_ctrl
#(
   parameter logic [7:0] ERASE_SETUP_CODE   = 8'h20,
   parameter logic [7:0] ERASE_CONFIRM_CODE = 8'hd0,
   parameter logic [7:0] READ_STATUS_CODE   = 8'h70,
   parameter int         T_WB_NS            = 500
)
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   output fsbe_pkg::fsbe_pins_type    flash_pins,
   input  wire logic [7:0]            flash_dq_in,
   input  wire logic                  ready_busy_output
);

   localparam int WB_CYC = (T_WB_NS + fsbe_pkg::CLK_NS - 1)
                           / fsbe_pkg::CLK_NS;
   localparam logic [fsbe_pkg::CNT_W-1:0] WE_LAST =
      fsbe_pkg::CNT_W'(fsbe_pkg::WE_CYC - 1);
   localparam logic [fsbe_pkg::CNT_W-1:0] RD_LAST =
      fsbe_pkg::CNT_W'(fsbe_pkg::RD_CYC - 1);
   localparam logic [fsbe_pkg::CNT_W-1:0] WB_LAST =
      fsbe_pkg::CNT_W'((WB_CYC < 1 ? 1 : WB_CYC) - 1);

   fsbe_pkg::fsbe_state_type s_q;
   fsbe_pkg::fsbe_state_type s_d;

   logic acc;
   logic wr_acc;
   logic busy;
   logic mapped;

   assign acc    = psel && penable;
   assign wr_acc = acc && pwrite;
   assign busy   = (s_q.st != fsbe_pkg::S_IDLE);
   assign mapped = (paddr == fsbe_pkg::REG_CTRL)
                || (paddr == fsbe_pkg::REG_ADDR)
                || (paddr == fsbe_pkg::REG_STATUS);

   // zero wait state slave
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;

   always_comb
   begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite)
      begin
         case (paddr)
            fsbe_pkg::REG_CTRL:
               prdata[1:0] = s_q.op;
            fsbe_pkg::REG_ADDR:
               prdata[fsbe_pkg::FL_AW-1:0] = s_q.addr;
            fsbe_pkg::REG_STATUS:
            begin
               prdata[fsbe_pkg::ST_BUSY_BIT] = busy;
               prdata[fsbe_pkg::ST_DONE_BIT] = s_q.done;
               prdata[fsbe_pkg::ST_RB_BIT]   = s_q.rb_s2;
               // the byte keeps the device's sticky error bits as read;
               // a stale byte from the last operation is hidden while busy
               prdata[fsbe_pkg::ST_BYTE_LSB +: 8] = busy ? 8'h00
                                                         : s_q.stat;
            end
            default:
               prdata = 32'h0000_0000;
         endcase
      end
   end

   assign flash_pins = s_q.pins;

   always_comb
   begin
      s_d       = s_q;
      s_d.dq_s1 = flash_dq_in;
      s_d.dq_s2 = s_q.dq_s1;
      s_d.rb_s1 = ready_busy_output;
      s_d.rb_s2 = s_q.rb_s1;
      s_d.cnt   = s_q.cnt + 1'b1;

      if (wr_acc && !busy && paddr == fsbe_pkg::REG_ADDR)
         s_d.addr = pwdata[fsbe_pkg::FL_AW-1:0];

      case (s_q.st)
         fsbe_pkg::S_IDLE:
         begin
            s_d.pins = fsbe_pkg::PINS_IDLE;
            s_d.cnt  = fsbe_pkg::CNT_RESET;
            // commands written while busy are dropped, which also keeps
            // a clear-status off a running machine
            if (wr_acc && paddr == fsbe_pkg::REG_CTRL
                && pwdata[1:0] != fsbe_pkg::OP_NONE)
            begin
               s_d.op   = pwdata[1:0];
               s_d.idx  = 1'b0;
               s_d.done = 1'b0;
               s_d.st   = fsbe_pkg::S_WSETUP;
            end
         end
         fsbe_pkg::S_WSETUP:
         begin
            s_d.pins.ce_n   = 1'b0;
            s_d.pins.oe_n   = 1'b1;
            s_d.pins.we_n   = 1'b1;
            s_d.pins.addr   = s_q.addr;
            s_d.pins.dq_oe  = 1'b1;
            case (s_q.op)
               fsbe_pkg::OP_ERASE:
                  s_d.pins.dq_out = s_q.idx ? ERASE_CONFIRM_CODE
                                            : ERASE_SETUP_CODE;
               fsbe_pkg::OP_CLEAR:
                  s_d.pins.dq_out = fsbe_pkg::CMD_CLEAR_STATUS;
               default:
                  s_d.pins.dq_out = READ_STATUS_CODE;
            endcase
            s_d.cnt = fsbe_pkg::CNT_RESET;
            s_d.st  = fsbe_pkg::S_WPULSE;
         end
         fsbe_pkg::S_WPULSE:
         begin
            s_d.pins.we_n = 1'b0;
            if (s_q.cnt == WE_LAST)
               s_d.st = fsbe_pkg::S_WHOLD;
         end
         fsbe_pkg::S_WHOLD:
         begin
            // we rises first, data stays one more cycle for hold time
            s_d.pins.we_n = 1'b1;
            s_d.st        = fsbe_pkg::S_WGAP;
         end
         fsbe_pkg::S_WGAP:
         begin
            s_d.pins.ce_n  = 1'b1;
            s_d.pins.dq_oe = 1'b0;
            s_d.cnt        = fsbe_pkg::CNT_RESET;
            if (s_q.op == fsbe_pkg::OP_ERASE && !s_q.idx)
            begin
               // confirm goes out straight after setup
               s_d.idx = 1'b1;
               s_d.st  = fsbe_pkg::S_WSETUP;
            end
            else if (s_q.op == fsbe_pkg::OP_CLEAR)
            begin
               s_d.done = 1'b1;
               s_d.st   = fsbe_pkg::S_IDLE;
            end
            else
               s_d.st = fsbe_pkg::S_WB;
         end
         fsbe_pkg::S_WB:
         begin
            // no read before the device has switched to status output
            if (s_q.cnt == WB_LAST)
            begin
               s_d.cnt = fsbe_pkg::CNT_RESET;
               s_d.st  = fsbe_pkg::S_RPULSE;
            end
         end
         fsbe_pkg::S_RPULSE:
         begin
            // a fresh oe fall per poll makes the device relatch status
            s_d.pins.ce_n = 1'b0;
            s_d.pins.oe_n = 1'b0;
            if (s_q.cnt == RD_LAST)
            begin
               // bit 0 is masked; low bits are only trusted when ready
               if (s_q.dq_s2[fsbe_pkg::OS_READY])
                  s_d.stat = s_q.dq_s2 & fsbe_pkg::OS_MASK;
               else
                  s_d.stat = 8'h00;
               s_d.st = fsbe_pkg::S_RGAP;
            end
         end
         fsbe_pkg::S_RGAP:
         begin
            s_d.pins.ce_n = 1'b1;
            s_d.pins.oe_n = 1'b1;
            s_d.cnt       = fsbe_pkg::CNT_RESET;
            if (s_q.stat[fsbe_pkg::OS_READY])
            begin
               // the device stays in status-read mode, nothing to undo
               s_d.done = 1'b1;
               s_d.st   = fsbe_pkg::S_IDLE;
            end
            else
               s_d.st = fsbe_pkg::S_RPULSE;
         end
         default:
         begin
            s_d.pins = fsbe_pkg::PINS_IDLE;
            s_d.st   = fsbe_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q       <= '0;
         s_q.st    <= fsbe_pkg::S_IDLE;
         s_q.pins  <= fsbe_pkg::PINS_IDLE;
      end
      else if (clk_en)
         s_q <= s_d;
   end

endmodule

//--- verification/fsbe_dev.sv
`timescale 1ns/1ps
module fsbe_dev
(
   input  wire logic                    pclk,
   input  wire fsbe_pkg::fsbe_pins_type pins,
   input  wire logic                    locked,
   input  wire logic                    low_vpp,
   input  wire logic [7:0]              busy_cyc,
   output logic [7:0]                   dq,
   output logic                         rb
);
   logic [7:0]  err_q = 8'h00;
   logic [7:0]  lat_q = 8'h00;
   logic [7:0]  cmd_q = 8'h00;
   logic [7:0]  tog_q = 8'h5a;
   logic        setup_q = 1'b0;
   logic [23:0] ers_addr = 24'h000000;
   int          busy_n = 0;
   int          erased_n = 0;
   wire  [7:0]  st = {rb, err_q[6:1], 1'b1};
   assign rb = (busy_n == 0);
   // unselected or busy lines show a moving pattern, never stale data
   assign dq = (pins.ce_n | pins.oe_n) ? tog_q :
               (lat_q[7] ? lat_q : {1'b0, tog_q[6:0]});
   always @(negedge pins.oe_n) lat_q = st;
   always @(posedge pclk)
   begin
      tog_q <= ~tog_q;
      if (busy_n > 0) busy_n = busy_n - 1;
   end
   always @(posedge pins.we_n)
   begin
      cmd_q = pins.dq_out;
      if (cmd_q == 8'h50 && rb) err_q = 8'h00;
      else if (setup_q)
      begin
         if (cmd_q != 8'hd0) err_q |= 8'h30;
         else if (low_vpp) err_q |= 8'h28;
         else if (locked) err_q |= 8'h22;
         else
         begin
            busy_n = busy_cyc;
            erased_n++;
            ers_addr = pins.addr;
         end
      end
      setup_q = (cmd_q == 8'h20) && !setup_q;
   end
endmodule

//--- verification/fsbe_chk.sv
`timescale 1ns/1ps
module fsbe_chk
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             prdata,
   input wire fsbe_pkg::fsbe_pins_type flash_pins,
   input wire logic                    ready_busy_output
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire st_rd = psel && !pwrite && paddr == fsbe_pkg::REG_STATUS;
   sequence s_we_tail;
      !flash_pins.we_n ##1 (flash_pins.we_n && !flash_pins.ce_n)
      ##1 (flash_pins.ce_n && !flash_pins.dq_oe);
   endsequence
   sequence s_rd_pulse;
      !flash_pins.oe_n [*4] ##1 flash_pins.oe_n;
   endsequence
   a_we_tail: assert property ($fell(flash_pins.we_n) |=> s_we_tail)
      else $error("write strobe shape wrong");
   a_oe_toggle: assert property ($fell(flash_pins.oe_n) |=> s_rd_pulse)
      else $error("read strobe shape wrong");
   a_we_with_ce: assert property
      (!flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.dq_oe)
      else $error("write strobe without select or data");
   a_no_contend: assert property
      (!flash_pins.oe_n |-> !flash_pins.dq_oe && flash_pins.we_n)
      else $error("data driven during read");
   a_mask_rsvd: assert property (st_rd |-> !prdata[8])
      else $error("reserved status bit not masked");
   a_busy_zero: assert property (st_rd && prdata[0] |-> !prdata[15:8])
      else $error("status byte shown while busy");
   a_confirm_next: assert property
      ($fell(flash_pins.we_n) && flash_pins.dq_out == 8'h20 |->
       ##[1:8] ($fell(flash_pins.we_n) && flash_pins.dq_out == 8'hd0))
      else $error("setup not followed by confirm");
   a_clear_idle: assert property
      ($fell(flash_pins.we_n) && flash_pins.dq_out == 8'h50 |->
       ready_busy_output)
      else $error("clear sent while device busy");
endmodule
bind fsbe_ctrl fsbe_chk u_fsbe_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .flash_pins(flash_pins), .ready_busy_output(ready_busy_output));

//--- verification/tb_flash_status_and_block_erase.sv
`timescale 1ns/1ps
module tb_flash_status_and_block_erase;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic locked = 0, low_vpp = 0, pready, pslverr, err, rb;
   logic [11:0]             paddr = 12'h000;
   logic [31:0]             pwdata = 32'h0, prdata, rd;
   logic [7:0]              dq;
   fsbe_pkg::fsbe_pins_type pins;
   int                      error_cnt = 0, n_tests = 0;
   always #25 pclk = ~pclk;
   fsbe_ctrl #(.T_WB_NS(50)) u_fsbe_ctrl (.pclk, .presetn, .clk_en(1'b1),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .flash_pins(pins), .flash_dq_in(dq),
      .ready_busy_output(rb));
   fsbe_dev u_fsbe_dev (.pclk, .pins, .locked, .low_vpp,
      .busy_cyc(8'h28), .dq, .rb);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata, penable} <= {1'b1, w, a, d, 1'b0};
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until the edge that sees pready; answer taken there
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) chk(1'b0, 1'b1);
      if (pready !== 1'b1) report_and_stop();
      {psel, penable} <= 2'b00;
   endtask
   task run(input logic [1:0] op);
      int n;
      apb(1'b1, fsbe_pkg::REG_CTRL, {30'h0, op});
      for (n = 0; n < 300; n++)
      begin
         apb(1'b0, fsbe_pkg::REG_STATUS, 32'h0);
         if (rd[0] === 1'b0 && rd[1] === 1'b1) break;
         if (rd[0] === 1'b1) chk(rd[15:8], 8'h00);
      end
      if (n == 300) chk(1'b0, 1'b1);
      if (n == 300) report_and_stop();
   endtask
   task t_erase_ok;
      apb(1'b0, 12'h00c, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, fsbe_pkg::REG_ADDR, 32'h00020010);
      apb(1'b0, fsbe_pkg::REG_ADDR, 32'h0);
      chk(rd, 32'h00020010);
      run(fsbe_pkg::OP_ERASE);
      chk(rd[15:8], 8'h80);
      chk(rd[2:0], 3'b110);
      apb(1'b0, fsbe_pkg::REG_CTRL, 32'h0);
      chk(rd, {30'h0, fsbe_pkg::OP_ERASE});
      chk(u_fsbe_dev.erased_n, 1);
      chk(u_fsbe_dev.ers_addr, 24'h020010);
   endtask
   task t_erase_err;
      locked <= 1'b1;
      run(fsbe_pkg::OP_ERASE);
      chk(rd[15:8], 8'ha2);
      chk(u_fsbe_dev.erased_n, 1);
      {locked, low_vpp} <= 2'b01;
      run(fsbe_pkg::OP_ERASE);
      chk(rd[15:8], 8'haa);
   endtask
   task t_clear;
      low_vpp <= 1'b0;
      run(fsbe_pkg::OP_CLEAR);
      chk(u_fsbe_dev.cmd_q, fsbe_pkg::CMD_CLEAR_STATUS);
      {locked, low_vpp} <= 2'b11;
      run(fsbe_pkg::OP_READ);
      chk(rd[15:8], 8'h80);
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_erase_ok();
      t_erase_err();
      t_clear();
      report_and_stop();
   end
endmodule
